// ===== inc/match_capture_timer32_defines.vh
// Register map, field positions and reset values of the match/capture timer
// Behaviour
// - Each compare match sets its compare event flag; writing one clears it.
// - Each capture into a captured value register sets its capture event flag; write one clears.
// - Divider and main count advance only while the run bit is one.
// - Hold-clear bit forces main count and divider to zero until it returns low.
// - Main count steps once per divider limit plus one counting events; read only.
// - Divider reaching its limit wraps to zero and steps the main count.
// - Action bit 3n enables the interrupt of compare n.
// - Action bit 3n+1 resets the count on a match of compare n.
// - Action bit 3n+2 stops both counters on a match and clears the run bit.
// - Rising-edge enable loads the captured value register on a 0-to-1 input change.
// - Falling-edge enable loads the captured value register on a 1-to-0 input change.
// - Capture interrupt enable turns enabled capture events into an interrupt.
// - Trigger start in timer mode lets the selected input set the run bit.
// - On match n, output state follows its action: keep, clear, set, toggle.
// - Each match output pin is the state, or its complement when inverted.
// - Source mode picks clock counting or rising, falling or both input edges.
// - Input select picks input 0 or 1; values 2 and 3 reserved.
// - Edge-clear enable clears both counters on the chosen capture edge.
// - Edge-clear choice: 0/1 input 0 rise/fall, 2/3 input 1 rise/fall.
// - Rising-edge reset plus falling-edge capture and interrupt measures a pulse.
`ifndef MATCH_CAPTURE_TIMER32_DEFINES_VH
`define MATCH_CAPTURE_TIMER32_DEFINES_VH

// ----------
// Byte addresses
// ----------
`define OFS_EVENT_FLAG_STATUS 24'h22_0000
`define OFS_COUNT_CONTROL 24'h22_0004
`define OFS_MAIN_COUNT 24'h22_0008
`define OFS_DIVIDER_LIMIT 24'h22_000c
`define OFS_DIVIDER_COUNT 24'h22_0010
`define OFS_MATCH_ACTION_CONTROL 24'h22_0014
`define OFS_COMPARE_VALUE_0 24'h22_0018
`define OFS_COMPARE_VALUE_1 24'h22_001c
`define OFS_COMPARE_VALUE_2 24'h22_0020
`define OFS_COMPARE_VALUE_3 24'h22_0024
`define OFS_CAPTURE_CONTROL 24'h22_0028
`define OFS_CAPTURED_VALUE_0 24'h22_002c
`define OFS_CAPTURED_VALUE_1 24'h22_0030
`define OFS_MATCH_OUTPUT_CONTROL 24'h22_003c
`define OFS_COUNT_SOURCE_CONTROL 24'h22_0070

// ----------
// Field positions
// ----------
`define FLAG_CAPTURE_0 4
`define RUN_BIT 0
`define HOLD_CLEAR_BIT 1
`define CAP_RISE_0 0
`define CAP_FALL_0 1
`define CAP_IRQ_0 2
`define CAP_STRIDE 3
`define TRIGGER_START_BIT 6
`define OUT_ACTION_LSB 4
`define OUT_INVERT_LSB 12
`define SRC_MODE_LSB 0
`define SRC_INPUT_LSB 2
`define EDGE_CLEAR_EN_BIT 4
`define EDGE_CLEAR_SEL_LSB 5

// ----------
// Encodings and reset values
// ----------
`define MODE_TIMER 2'h0
`define MODE_RISE 2'h1
`define MODE_FALL 2'h2
`define MODE_BOTH 2'h3
`define ACT_KEEP 2'h0
`define ACT_CLEAR 2'h1
`define ACT_SET 2'h2
`define ACT_TOGGLE 2'h3
`define ZERO32 32'h0000_0000

`endif

// ===== verilog/match_capture_timer32.v
// 32-bit timer with prescaler, four compares, two captures and an Avalon-MM slave
`default_nettype none
`include "match_capture_timer32_defines.vh"

module match_capture_timer32 (
    input wire core_clk,
    input wire rst,
    input wire [23:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire capture_input_0,
    input wire capture_input_1,
    output reg [3:0] match_output_pin,
    output reg event_irq
);

    // ----------
    // Register state
    // ----------

    reg count_run;

    reg count_hold_clear;

    reg [31:0] main_count;

    reg [31:0] divider_limit;

    reg [31:0] divider_count;

    reg [11:0] match_action_control;

    reg [31:0] compare_value [0:3];

    reg [6:0] capture_control;

    reg [31:0] captured_value [0:1];

    reg [7:0] match_output_action;

    reg [3:0] match_output_invert;

    reg [3:0] match_output_state;

    reg [7:0] count_source_control;

    reg [5:0] event_flag_status;

    reg [31:0] next_main_count;

    reg [31:0] next_divider_count;

    reg next_count_run;

    // ----------
    // Bus slave: one wait state on every access
    // ----------

    reg ack;

    wire access = avs_read | avs_write;

    wire wr_en = avs_write & ack;

    assign avs_waitrequest = access & ~ack;

    always @(posedge core_clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= access & ~ack;
        end
    end

    // ----------
    // Input synchroniser and edge detect
    // ----------

    // Third stage keeps the metastable first stage out of the edge logic
    reg [1:0] cap_meta;
    reg [1:0] cap_sync;
    reg [1:0] cap_last;
    wire [1:0] cap_rise = cap_sync & ~cap_last;
    wire [1:0] cap_fall = ~cap_sync & cap_last;

    always @(posedge core_clk) begin
        if (rst) begin
            cap_meta <= 2'h0;
            cap_sync <= 2'h0;
            cap_last <= 2'h0;
        end else begin
            cap_meta <= {capture_input_1, capture_input_0};
            cap_sync <= cap_meta;
            cap_last <= cap_sync;
        end
    end

    // ----------
    // Counting event selection
    // ----------

    wire [1:0] src_mode = count_source_control[`SRC_MODE_LSB +: 2];

    wire [1:0] src_input = count_source_control[`SRC_INPUT_LSB +: 2];

    wire clear_en = count_source_control[`EDGE_CLEAR_EN_BIT];

    wire [2:0] clear_sel = count_source_control[`EDGE_CLEAR_SEL_LSB +: 3];

    reg sel_rise;

    reg sel_fall;

    reg count_event;

    reg edge_clear;

    always @* begin
        case (src_input)
            2'h0: begin
                sel_rise = cap_rise[0];
                sel_fall = cap_fall[0];
            end
            2'h1: begin
                sel_rise = cap_rise[1];
                sel_fall = cap_fall[1];
            end
            default: begin
                // Reserved selections see no input edges
                sel_rise = 1'b0;
                sel_fall = 1'b0;
            end
        endcase
        case (src_mode)
            `MODE_TIMER: count_event = 1'b1;
            `MODE_RISE: count_event = sel_rise;
            `MODE_FALL: count_event = sel_fall;
            `MODE_BOTH: count_event = sel_rise | sel_fall;
            default: count_event = 1'b0;
        endcase
        case (clear_sel)
            3'h0: edge_clear = cap_rise[0];
            3'h1: edge_clear = cap_fall[0];
            3'h2: edge_clear = cap_rise[1];
            3'h3: edge_clear = cap_fall[1];
            default: edge_clear = 1'b0;
        endcase
        edge_clear = edge_clear & clear_en;
    end

    // ----------
    // Compare matches and match outputs
    // ----------

    // A match acts once, on the cycle the count arrives at the value;
    // equal_last resets high so a zero compare does not fire out of reset
    reg [3:0] equal_last;

    wire [3:0] equal_now;

    wire [3:0] match_hit;

    wire [3:0] reset_hit;

    wire [3:0] stop_hit;

    wire [3:0] match_irq_en;

    genvar n;
    generate
        for (n = 0; n < 4; n = n + 1) begin : g_match
            assign equal_now[n] = (main_count == compare_value[n]);
            assign match_hit[n] = equal_now[n] & ~equal_last[n];
            assign match_irq_en[n] = match_action_control[3 * n];
            assign reset_hit[n] = match_hit[n] & match_action_control[3 * n + 1];
            assign stop_hit[n] = match_hit[n] & match_action_control[3 * n + 2];

            always @(posedge core_clk) begin
                if (rst) begin
                    match_output_state[n] <= 1'b0;
                    match_output_pin[n] <= 1'b0;
                end else begin
                    if (match_hit[n]) begin
                        case (match_output_action[2 * n +: 2])
                            `ACT_KEEP: match_output_state[n] <= match_output_state[n];
                            `ACT_CLEAR: match_output_state[n] <= 1'b0;
                            `ACT_SET: match_output_state[n] <= 1'b1;
                            `ACT_TOGGLE: match_output_state[n] <= ~match_output_state[n];
                            default: match_output_state[n] <= match_output_state[n];
                        endcase
                    end
                    // Pin lags the state by one cycle so it leaves a flip-flop
                    match_output_pin[n] <= match_output_state[n] ^ match_output_invert[n];
                end
            end
        end
    endgenerate

    always @(posedge core_clk) begin
        if (rst) begin
            equal_last <= 4'hf;
        end else begin
            equal_last <= equal_now;
        end
    end

    // ----------
    // Prescaler and main count
    // ----------

    wire any_stop = |stop_hit;
    wire trigger_start = capture_control[`TRIGGER_START_BIT] & (src_mode == `MODE_TIMER)
        & sel_rise;
    wire tick = count_run & ~any_stop & count_event;

    always @* begin
        next_main_count = main_count;
        next_divider_count = divider_count;
        if (count_hold_clear) begin
            next_main_count = `ZERO32;
            next_divider_count = `ZERO32;
        end else if (edge_clear) begin
            next_main_count = `ZERO32;
            next_divider_count = `ZERO32;
        end else if (|reset_hit) begin
            next_main_count = `ZERO32;
            next_divider_count = `ZERO32;
        end else if (tick) begin
            if (divider_count == divider_limit) begin
                next_divider_count = `ZERO32;
                next_main_count = main_count + 32'h0000_0001;
            end else begin
                next_divider_count = divider_count + 32'h0000_0001;
            end
        end
    end

    always @* begin
        next_count_run = count_run;
        if (wr_en && avs_address == `OFS_COUNT_CONTROL) begin
            next_count_run = avs_writedata[`RUN_BIT];
        end
        if (trigger_start) begin
            next_count_run = 1'b1;
        end
        // A stop wins over a start arriving in the same cycle
        if (any_stop) begin
            next_count_run = 1'b0;
        end
    end

    always @(posedge core_clk) begin
        if (rst) begin
            main_count <= `ZERO32;
            divider_count <= `ZERO32;
            count_run <= 1'b0;
        end else begin
            main_count <= next_main_count;
            divider_count <= next_divider_count;
            count_run <= next_count_run;
        end
    end

    // ----------
    // Captures, flags and interrupt
    // ----------

    wire [1:0] cap_event;

    wire [1:0] cap_irq_en;

    wire [5:0] flag_set;

    wire [5:0] flag_clr;

    generate
        for (n = 0; n < 2; n = n + 1) begin : g_capture
            assign cap_event[n] =
                (capture_control[`CAP_STRIDE * n + `CAP_RISE_0] & cap_rise[n])
                | (capture_control[`CAP_STRIDE * n + `CAP_FALL_0] & cap_fall[n]);
            assign cap_irq_en[n] = capture_control[`CAP_STRIDE * n + `CAP_IRQ_0];

            always @(posedge core_clk) begin
                if (rst) begin
                    captured_value[n] <= `ZERO32;
                end else if (cap_event[n]) begin
                    captured_value[n] <= main_count;
                end
            end
        end
    endgenerate

    assign flag_set = {cap_event, match_hit};
    assign flag_clr = (wr_en && avs_address == `OFS_EVENT_FLAG_STATUS) ?
        avs_writedata[5:0] : 6'h00;

    always @(posedge core_clk) begin
        if (rst) begin
            event_flag_status <= 6'h00;
            event_irq <= 1'b0;
        end else begin
            // Set wins over a clear written in the same cycle
            event_flag_status <= (event_flag_status & ~flag_clr) | flag_set;
            event_irq <= |(((event_flag_status & ~flag_clr) | flag_set)
                & {cap_irq_en, match_irq_en});
        end
    end

    // ----------
    // Register writes and reads
    // ----------

    always @(posedge core_clk) begin
        if (rst) begin
            count_hold_clear <= 1'b0;
            divider_limit <= `ZERO32;
            match_action_control <= 12'h000;
            compare_value[0] <= `ZERO32;
            compare_value[1] <= `ZERO32;
            compare_value[2] <= `ZERO32;
            compare_value[3] <= `ZERO32;
            capture_control <= 7'h00;
            match_output_action <= 8'h00;
            match_output_invert <= 4'h0;
            count_source_control <= 8'h00;
        end else if (wr_en) begin
            case (avs_address)
                `OFS_COUNT_CONTROL: count_hold_clear <= avs_writedata[`HOLD_CLEAR_BIT];
                `OFS_DIVIDER_LIMIT: divider_limit <= avs_writedata;
                `OFS_MATCH_ACTION_CONTROL: match_action_control <= avs_writedata[11:0];
                `OFS_COMPARE_VALUE_0: compare_value[0] <= avs_writedata;
                `OFS_COMPARE_VALUE_1: compare_value[1] <= avs_writedata;
                `OFS_COMPARE_VALUE_2: compare_value[2] <= avs_writedata;
                `OFS_COMPARE_VALUE_3: compare_value[3] <= avs_writedata;
                `OFS_CAPTURE_CONTROL: capture_control <= avs_writedata[6:0];
                `OFS_MATCH_OUTPUT_CONTROL: begin
                    match_output_action <= avs_writedata[`OUT_ACTION_LSB +: 8];
                    match_output_invert <= avs_writedata[`OUT_INVERT_LSB +: 4];
                end
                `OFS_COUNT_SOURCE_CONTROL: count_source_control <= avs_writedata[7:0];
                default: count_hold_clear <= count_hold_clear;
            endcase
        end
    end

    // Read data is latched in the wait cycle and stands at the accepting edge
    always @(posedge core_clk) begin
        if (rst) begin
            avs_readdata <= `ZERO32;
        end else if (avs_read & ~ack) begin
            case (avs_address)
                `OFS_EVENT_FLAG_STATUS: avs_readdata <= {26'h0, event_flag_status};
                `OFS_COUNT_CONTROL: avs_readdata <= {30'h0, count_hold_clear, count_run};
                `OFS_MAIN_COUNT: avs_readdata <= main_count;
                `OFS_DIVIDER_LIMIT: avs_readdata <= divider_limit;
                `OFS_DIVIDER_COUNT: avs_readdata <= divider_count;
                `OFS_MATCH_ACTION_CONTROL: avs_readdata <= {20'h0_0000, match_action_control};
                `OFS_COMPARE_VALUE_0: avs_readdata <= compare_value[0];
                `OFS_COMPARE_VALUE_1: avs_readdata <= compare_value[1];
                `OFS_COMPARE_VALUE_2: avs_readdata <= compare_value[2];
                `OFS_COMPARE_VALUE_3: avs_readdata <= compare_value[3];
                `OFS_CAPTURE_CONTROL: avs_readdata <= {25'h0, capture_control};
                `OFS_CAPTURED_VALUE_0: avs_readdata <= captured_value[0];
                `OFS_CAPTURED_VALUE_1: avs_readdata <= captured_value[1];
                `OFS_MATCH_OUTPUT_CONTROL: avs_readdata <= {16'h0000, match_output_invert,
                    match_output_action, match_output_state};
                `OFS_COUNT_SOURCE_CONTROL: avs_readdata <= {24'h00_0000, count_source_control};
                default: avs_readdata <= `ZERO32;
            endcase
        end
    end

endmodule // match_capture_timer32
`default_nettype wire

// ===== sim/match_capture_timer32_checker.sv
// Port checker for the match/capture timer, bound to its top module
`default_nettype none
`include "match_capture_timer32_defines.vh"
module match_capture_timer32_checker (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [23:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic capture_input_0,
    input wire logic capture_input_1,
    input wire logic [3:0] match_output_pin,
    input wire logic event_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------
    // Shadows of written control fields
    // ----------
    logic wr_acc;
    logic hold_q;
    logic [6:0] cap_q;
    logic [11:0] mcr_q;
    logic [3:0] inv_q;
    logic [2:0] quiet;
    logic cmp_irq;
    logic en_any;
    assign wr_acc = avs_write && !avs_waitrequest;
    assign cmp_irq = mcr_q[0] || mcr_q[3] || mcr_q[6] || mcr_q[9];
    assign en_any = cmp_irq || cap_q[2] || cap_q[5];
    always @(posedge core_clk) begin
        if (rst) begin
            hold_q <= 1'b0;
            cap_q <= 7'h0;
            mcr_q <= 12'h0;
            inv_q <= 4'h0;
        end else if (wr_acc) begin
            if (avs_address == `OFS_COUNT_CONTROL) hold_q <= avs_writedata[1];
            if (avs_address == `OFS_CAPTURE_CONTROL) cap_q <= avs_writedata[6:0];
            if (avs_address == `OFS_MATCH_ACTION_CONTROL) mcr_q <= avs_writedata[11:0];
            if (avs_address == `OFS_MATCH_OUTPUT_CONTROL) inv_q <= avs_writedata[15:12];
        end
    end
    // Pin edges need three stages to land, so flag checks wait out the pipe
    always @(posedge core_clk) begin
        if (rst || $changed(capture_input_0) || $changed(capture_input_1)) quiet <= 3'h0;
        else if (quiet != 3'h7) quiet <= quiet + 3'h1;
    end
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest longer than one cycle");
    AST_UNMAPPED_ZERO: assert property (avs_read && !avs_waitrequest && avs_address[23:16] != 8'h22
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_IRQ_GATED: assert property (!en_any && !$past(en_any) |-> !event_irq)
        else $error("interrupt with all enables off");
    AST_PIN_INVERT: assert property ($changed(inv_q) |=>
        (match_output_pin ^ $past(match_output_pin)) == (inv_q ^ $past(inv_q, 2)))
        else $error("pin did not follow inversion");
    AST_CAP_SYNC: assert property ($rose(capture_input_0) && cap_q[0] && cap_q[2] && !event_irq
        |=> !event_irq ##[1:3] event_irq) else $error("capture interrupt timing wrong");
    AST_HOLD_READ: assert property (avs_read && !avs_waitrequest && hold_q && $past(hold_q, 3)
        && (avs_address == `OFS_MAIN_COUNT || avs_address == `OFS_DIVIDER_COUNT)
        |-> avs_readdata == 32'h0) else $error("count not held at zero");
    AST_FLAG_CLEAR: assert property (wr_acc && avs_address == `OFS_EVENT_FLAG_STATUS
        && avs_writedata[5:0] == 6'h3f && quiet == 3'h7 && !cmp_irq |-> ##[1:2] !event_irq)
        else $error("interrupt kept after flags cleared");
    AST_IRQ_HOLD: assert property (event_irq && !wr_acc && !$past(wr_acc) |=> event_irq)
        else $error("interrupt dropped without a write");
    cover property (wr_acc && avs_address == `OFS_COUNT_CONTROL && avs_writedata[0]);
    cover property ($rose(event_irq));
    cover property ($changed(match_output_pin[1]));
endmodule // match_capture_timer32_checker
bind match_capture_timer32 match_capture_timer32_checker match_capture_timer32_checker_inst (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .capture_input_0(capture_input_0),
    .capture_input_1(capture_input_1), .match_output_pin(match_output_pin),
    .event_irq(event_irq));
`default_nettype wire

// ===== sim/capture_pins_model.sv
// Model of the external capture pins and a watcher of the match pins
`default_nettype none
module capture_pins_model (
    input wire logic core_clk,
    input wire logic [3:0] match_output_pin,
    output logic capture_input_0 = 1'b0,
    output logic capture_input_1 = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int toggles = 0;
    logic [3:0] pin_d = 4'h0;
    always @(posedge core_clk) begin
        pin_d <= match_output_pin;
        if (match_output_pin[1] !== pin_d[1]) toggles <= toggles + 1;
    end
    // Each level is held five cycles so the synchroniser always sees it
    task automatic drive(input int idx, input logic v);
        @(posedge core_clk);
        if (idx == 0) capture_input_0 <= v;
        else capture_input_1 <= v;
        repeat (5) @(posedge core_clk);
    endtask
endmodule // capture_pins_model
`default_nettype wire

// ===== sim/match_capture_timer32_tb.sv
// Self-checking testbench of the match/capture timer
`default_nettype none
`include "match_capture_timer32_defines.vh"
module match_capture_timer32_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [23:0] avs_address = 24'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic capture_input_0;
    logic capture_input_1;
    logic [3:0] match_output_pin;
    logic event_irq;
    logic [31:0] q;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    always #50 core_clk = ~core_clk;
    match_capture_timer32 match_capture_timer32_inst (.core_clk(core_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .capture_input_0(capture_input_0),
        .capture_input_1(capture_input_1), .match_output_pin(match_output_pin),
        .event_irq(event_irq));
    capture_pins_model capture_pins_model_inst (.core_clk(core_clk),
        .match_output_pin(match_output_pin), .capture_input_0(capture_input_0),
        .capture_input_1(capture_input_1));
    // ----------
    // Shared tasks
    // ----------
    task automatic conclude();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic miss(input string s);
        err_total++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) miss($sformatf("value %h, expected %h", got, exp));
    endtask
    task automatic chk_pins(input logic [3:0] exp);
        n_compared++;
        if (match_output_pin !== exp) miss("match pins wrong");
    endtask
    task automatic chk_irq(input logic exp);
        n_compared++;
        if (event_irq !== exp) miss("interrupt level wrong");
    endtask
    // Holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [23:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [23:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rchk(input logic [23:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic pin(input int i, input logic v);
        capture_pins_model_inst.drive(i, v);
    endtask
    task automatic pulse(input int i);
        pin(i, 1'b1);
        pin(i, 1'b0);
    endtask
    task automatic done(input string s);
        $display("%s finished, %0d mismatches so far", s, err_total);
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_reset();
        logic [23:0] regs [13] = '{`OFS_COUNT_CONTROL, `OFS_MAIN_COUNT, `OFS_DIVIDER_LIMIT,
            `OFS_DIVIDER_COUNT, `OFS_MATCH_ACTION_CONTROL, `OFS_COMPARE_VALUE_0,
            `OFS_CAPTURE_CONTROL, `OFS_CAPTURED_VALUE_0, `OFS_CAPTURED_VALUE_1,
            `OFS_MATCH_OUTPUT_CONTROL, `OFS_COUNT_SOURCE_CONTROL, `OFS_EVENT_FLAG_STATUS,
            24'h10_0000};
        foreach (regs[i]) rchk(regs[i], 32'h0);
        chk_pins(4'h0);
        chk_irq(1'b0);
        done("reset");
    endtask
    task automatic t_stop();
        wr(`OFS_COMPARE_VALUE_0, 32'h5);
        wr(`OFS_MATCH_ACTION_CONTROL, 32'h5);
        wr(`OFS_MATCH_OUTPUT_CONTROL, 32'h4020);
        cyc(2);
        chk_pins(4'h4);
        rchk(`OFS_COMPARE_VALUE_0, 32'h5);
        wr(`OFS_COUNT_CONTROL, 32'h1);
        while (event_irq !== 1'b1) @(posedge core_clk);
        cyc(3);
        rchk(`OFS_MAIN_COUNT, 32'h5);
        rchk(`OFS_COUNT_CONTROL, 32'h0);
        rchk(`OFS_EVENT_FLAG_STATUS, 32'h1);
        rchk(`OFS_MATCH_OUTPUT_CONTROL, 32'h4021);
        chk_pins(4'h5);
        rchk(`OFS_MAIN_COUNT, 32'h5);
        wr(`OFS_EVENT_FLAG_STATUS, 32'h1);
        cyc(2);
        chk_irq(1'b0);
        done("stop on match");
    endtask
    task automatic t_capture();
        wr(`OFS_MATCH_ACTION_CONTROL, 32'h0);
        wr(`OFS_CAPTURE_CONTROL, 32'h15);
        pin(0, 1'b1);
        chk_irq(1'b1);
        rchk(`OFS_CAPTURED_VALUE_0, 32'h5);
        rchk(`OFS_EVENT_FLAG_STATUS, 32'h10);
        wr(`OFS_EVENT_FLAG_STATUS, 32'h3f);
        pin(1, 1'b1);
        chk_irq(1'b0);
        pin(1, 1'b0);
        rchk(`OFS_CAPTURED_VALUE_1, 32'h5);
        rchk(`OFS_EVENT_FLAG_STATUS, 32'h20);
        chk_irq(1'b0);
        pin(0, 1'b0);
        rchk(`OFS_EVENT_FLAG_STATUS, 32'h20);
        wr(`OFS_EVENT_FLAG_STATUS, 32'h3f);
        done("capture");
    endtask
    task automatic t_hold();
        wr(`OFS_MAIN_COUNT, 32'h1234);
        rchk(`OFS_MAIN_COUNT, 32'h5);
        wr(`OFS_COUNT_CONTROL, 32'h2);
        cyc(2);
        rchk(`OFS_MAIN_COUNT, 32'h0);
        wr(`OFS_COUNT_CONTROL, 32'h3);
        cyc(4);
        rchk(`OFS_MAIN_COUNT, 32'h0);
        rchk(`OFS_DIVIDER_COUNT, 32'h0);
        wr(`OFS_COUNT_CONTROL, 32'h0);
        done("hold clear");
    endtask
    task automatic t_counter();
        wr(`OFS_CAPTURE_CONTROL, 32'h0);
        wr(`OFS_DIVIDER_LIMIT, 32'h1);
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h5);
        wr(`OFS_COUNT_CONTROL, 32'h1);
        pulse(0);
        for (int i = 0; i < 4; i++) pulse(1);
        rchk(`OFS_MAIN_COUNT, 32'h2);
        rchk(`OFS_DIVIDER_COUNT, 32'h0);
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h7);
        pulse(1);
        rchk(`OFS_MAIN_COUNT, 32'h3);
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h6);
        pin(1, 1'b1);
        rchk(`OFS_DIVIDER_COUNT, 32'h0);
        pin(1, 1'b0);
        rchk(`OFS_DIVIDER_COUNT, 32'h1);
        done("counter mode");
    endtask
    task automatic t_edge_clear();
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h35);
        pin(0, 1'b1);
        rchk(`OFS_MAIN_COUNT, 32'h3);
        pin(0, 1'b0);
        rchk(`OFS_MAIN_COUNT, 32'h0);
        rchk(`OFS_DIVIDER_COUNT, 32'h0);
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h75);
        pin(1, 1'b1);
        rchk(`OFS_DIVIDER_COUNT, 32'h1);
        pin(1, 1'b0);
        rchk(`OFS_DIVIDER_COUNT, 32'h0);
        done("edge clear");
    endtask
    task automatic t_trigger();
        wr(`OFS_COUNT_CONTROL, 32'h0);
        wr(`OFS_COUNT_SOURCE_CONTROL, 32'h0);
        wr(`OFS_CAPTURE_CONTROL, 32'h40);
        pin(0, 1'b1);
        rchk(`OFS_COUNT_CONTROL, 32'h1);
        pin(0, 1'b0);
        done("trigger start");
    endtask
    task automatic t_match_reset();
        int base;
        wr(`OFS_COUNT_CONTROL, 32'h2);
        wr(`OFS_DIVIDER_LIMIT, 32'h0);
        wr(`OFS_COMPARE_VALUE_1, 32'h3);
        wr(`OFS_MATCH_ACTION_CONTROL, 32'h10);
        wr(`OFS_MATCH_OUTPUT_CONTROL, 32'h40c0);
        wr(`OFS_COUNT_CONTROL, 32'h1);
        cyc(4);
        base = capture_pins_model_inst.toggles;
        cyc(40);
        chk(32'(capture_pins_model_inst.toggles - base), 32'ha);
        bus(1'b0, `OFS_MAIN_COUNT, 32'h0);
        chk(q >> 2, 32'h0);
        wr(`OFS_COUNT_CONTROL, 32'h0);
        done("match reset");
    endtask
    initial begin
        cyc(3);
        rst <= 1'b0;
        t_reset();
        t_stop();
        t_capture();
        t_hold();
        t_counter();
        t_edge_clear();
        t_trigger();
        t_match_reset();
        conclude();
    end
endmodule // match_capture_timer32_tb
`default_nettype wire
